//--- rst_seq_pkg.sv
package rst_seq_pkg;
  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFS_SEL = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h1;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h3;
  // reset flag register bit positions
  localparam int FLG_TIMEOUT = 0;
  localparam int FLG_PDF = 1;
  localparam int FLG_DROP = 2;
  localparam int FLG_BAD = 3;
  // event bit positions in status and mask
  localparam int EVT_WDT = 0;
  localparam int EVT_PIN = 1;
  localparam int EVT_DROP = 2;
  localparam int EVT_BAD = 3;
  localparam int EVT_N = 4;
  localparam logic [EVT_N-1:0] EVT_NONE = 4'h0;
  // threshold codes
  localparam logic [7:0] CODE_2V10 = 8'h55;
  localparam logic [7:0] CODE_2V55 = 8'h33;
  localparam logic [7:0] CODE_3V15 = 8'h99;
  localparam logic [7:0] CODE_3V80 = 8'haa;
  localparam logic [7:0] SEL_POR = CODE_2V10;
  // power modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_SLEEP = 2'b11
  } power_mode_e;
  // system clock sources
  typedef enum logic [1:0] {
    SRC_FAST_INTERNAL_RC = 2'b00,
    SRC_HXT = 2'b01,
    SRC_SLOW_INTERNAL_RC = 2'b10,
    SRC_SPARE = 2'b11
  } clk_src_e;
  // start-up delay after a low-power watchdog wake, system clock cycles
  localparam logic [7:0] STARTUP_FAST_INTERNAL_RC_CYC = 8'h10;
  localparam logic [7:0] STARTUP_HXT_CYC = 8'h80;
  localparam logic [7:0] STARTUP_SLOW_INTERNAL_RC_CYC = 8'h02;
  // clock rates and slow rc reset delay
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned SLOW_INTERNAL_RC_HZ = 32_000;
  localparam int unsigned SLOW_INTERNAL_RC_DIV = SYS_CLK_HZ / SLOW_INTERNAL_RC_HZ;
  localparam int unsigned RST_DELAY_SLOW_INTERNAL_RC = 3;
endpackage : rst_seq_pkg

//--- sync2.sv
`timescale 1ns/1ns
`default_nettype none
// two flip-flop synchroniser for one asynchronous level
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and synchronised level out
  input wire logic d,
  output logic q
);
  logic meta_reg; // first stage, read only by q

  // two stages, nothing else looks at the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : sync2
`default_nettype wire

//--- tick_delay.sv
`timescale 1ns/1ns
`default_nettype none
// fires once after req has stood through TICKS slow ticks
module tick_delay #(
  parameter int unsigned TICKS = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // slow rate enable and request level
  input wire logic tick,
  input wire logic req,
  // one-cycle pulse when the delay ends
  output logic fire
);
  localparam int CW = $clog2(TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(TICKS - 1);
  logic [CW-1:0] cnt_reg; // ticks seen while req stood
  logic done_reg; // fired, wait for req to drop

  // count ticks; a drop of req restarts, so glitches never fire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (!req) begin
        cnt_reg <= '0;
        done_reg <= 1'b0;
      end else if (tick && !done_reg) begin
        if (cnt_reg == LAST) begin
          fire <= 1'b1;
          done_reg <= 1'b1;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule : tick_delay
`default_nettype wire

//--- reset_flags_and_supply_drop_select.sv
// Overview of operation
// RQ1: low-power watchdog wake waits source-sized start-up delay
// RQ2: power-on clears time-out and power-down flags
// RQ3: pin or supply-drop reset keeps both flags
// RQ4: running watchdog reset sets time-out flag only
// RQ5: low-power watchdog reset sets both flags
// RQ6: power-on disables every interrupt source
// RQ7: power-on clears watchdog, which then counts
// RQ8: power-on switches all timer counters off
// RQ9: power-on makes pins inputs, analog pins converter
// RQ10: power-on puts stack pointer at top
// RQ11: threshold select holds four valid 8-bit codes
// RQ12: threshold select powers up at 2.1 V code
// RQ13: bad code resets after 2-3 slow ticks, reloads
// RQ14: supply drop resets after 2-3 ticks, keeps code
// RQ15: reset kind sets register values; PC low clears
// RQ16: supply-drop flag set by drop, software clears
// RQ17: bad-code flag set by bad code, software clears
// RQ18: reset requests filtered on the slow rc rate
`timescale 1ns/1ns
`default_nettype none
module reset_flags_and_supply_drop_select
  import rst_seq_pkg::*;
#(
  parameter int unsigned DIV = SLOW_INTERNAL_RC_DIV,
  parameter int unsigned DELAY_TICKS = RST_DELAY_SLOW_INTERNAL_RC
) (
  // clock and power-on reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // reset sources
  input wire logic EXT_RESET_PIN_N,
  input wire logic SUPPLY_LOW,
  input wire logic WDT_TIMEOUT,
  // operating state of the core
  input wire logic [1:0] POWER_MODE,
  input wire logic [1:0] CLK_SOURCE,
  // reset and initialisation to the core
  output logic CORE_RESET,
  output logic RUN_ENABLE,
  output logic CORE_INIT,
  output logic PC_STACK_CLEAR,
  output logic WDT_CLEAR,
  output logic WDT_RUN,
  // state to the core and analog detector
  output logic [7:0] THRESHOLD_CODE,
  output logic TIMEOUT_FLAG,
  output logic POWER_DOWN_FLAG,
  // interrupt
  output logic IRQ
);
  localparam int DIV_W = $clog2(DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  // slow rc rate divider
  logic [DIV_W-1:0] div_reg; // system cycles within a slow period
  logic tick_reg; // one-cycle slow rc enable
  // synchronised inputs
  logic pin_n_s; // reset pin after two stages
  logic pin_n_d; // previous pin level for edge
  logic supply_low_s; // detector output after two stages
  // events of this cycle
  logic low_power; // idle or sleep mode
  logic pin_evt; // pin falling edge
  logic wdt_evt; // watchdog time-out
  logic drop_req; // supply drop while detection active
  logic drop_fire; // supply drop reset takes effect
  logic code_ok; // threshold code is one of four
  logic bad_fire; // bad code reset takes effect
  logic any_evt; // pin, supply-drop, bad-code or watchdog reset fires now
  logic full_evt; // a reset that re-initialises the core
  // registers
  logic [7:0] sel_reg; // threshold select
  logic timeout_reg; // time-out flag
  logic pdf_reg; // power-down flag
  logic drop_flag_reg; // supply-drop reset flag
  logic bad_flag_reg; // bad threshold flag
  logic [EVT_N-1:0] irq_stat_reg; // sticky events
  logic [EVT_N-1:0] irq_mask_reg; // event enables
  logic [EVT_N-1:0] irq_stat_next; // status after this cycle
  logic [EVT_N-1:0] irq_mask_next; // mask after this cycle
  logic [EVT_N-1:0] evt_vec; // events in status layout
  logic [DATA_W-1:0] flags_rd; // flag register read view
  logic [DATA_W-1:0] rdata_reg; // read data, one cycle after read
  // start-up and reset outputs
  logic [7:0] start_cnt_reg; // remaining start-up cycles
  logic [7:0] start_load; // start-up length for the source
  logic run_reg; // core may run
  logic core_reset_reg; // core held in reset
  logic core_init_reg; // power-on state to core blocks
  logic pc_clear_reg; // program counter low and stack clear
  logic wdt_clear_reg; // watchdog counter clear
  logic wdt_run_reg; // watchdog counting
  logic irq_reg; // interrupt level
  logic por_pulse_reg; // first cycle after power-on
  // register port decode
  logic wr_sel;
  logic wr_flags;
  logic wr_mask;
  logic rd_stat;
  assign wr_sel = WR && (ADDR == OFS_SEL);
  assign wr_flags = WR && (ADDR == OFS_FLAGS);
  assign wr_mask = WR && (ADDR == OFS_IRQ_MASK);
  assign rd_stat = RD && (ADDR == OFS_IRQ_STAT);
  // slow rc enable from the system clock
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end
  // reset pin, released high
  sync2 #(.RST_VAL(1'b1)) u_pin_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(EXT_RESET_PIN_N),
    .q(pin_n_s)
  );
  // supply detector level
  sync2 #(.RST_VAL(1'b0)) u_drop_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(SUPPLY_LOW),
    .q(supply_low_s)
  );
  // previous pin level
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_n_d <= 1'b1;
    end else begin
      pin_n_d <= pin_n_s;
    end
  end
  // event decode; supply-drop detection is off in power-down modes
  assign low_power = (POWER_MODE == MODE_IDLE) || (POWER_MODE == MODE_SLEEP);
  assign pin_evt = pin_n_d && !pin_n_s;
  assign wdt_evt = WDT_TIMEOUT;
  assign drop_req = supply_low_s && !low_power;
  assign code_ok = (sel_reg == CODE_2V10) || (sel_reg == CODE_2V55) // [RQ11]
    || (sel_reg == CODE_3V15) || (sel_reg == CODE_3V80);
  assign full_evt = pin_evt || drop_fire || bad_fire || (wdt_evt && !low_power);
  assign any_evt = full_evt || wdt_evt;
  // supply drop delay on the slow rate
  tick_delay #(.TICKS(DELAY_TICKS)) u_drop_delay ( // [RQ14] [RQ18]
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick_reg),
    .req(drop_req),
    .fire(drop_fire)
  );
  // bad code delay on the slow rate
  tick_delay #(.TICKS(DELAY_TICKS)) u_bad_delay ( // [RQ13] [RQ18]
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick_reg),
    .req(!code_ok),
    .fire(bad_fire)
  );
  // threshold select; reload wins over a write
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_reg <= SEL_POR; // [RQ12]
    end else if (bad_fire) begin
      sel_reg <= SEL_POR; // [RQ13]
    end else if (wr_sel) begin
      sel_reg <= WDATA; // drop reset leaves it alone [RQ14]
    end
  end
  // time-out and power-down flags, cleared only by power-on
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_reg <= 1'b0; // [RQ2]
      pdf_reg <= 1'b0; // [RQ2]
    end else if (wdt_evt) begin
      timeout_reg <= 1'b1; // [RQ4] [RQ5]
      if (low_power) begin
        pdf_reg <= 1'b1; // [RQ5]
      end
    end
    // pin and drop resets touch neither flag [RQ3]
  end
  // supply-drop and bad-code flags; set wins over clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      drop_flag_reg <= 1'b0;
      bad_flag_reg <= 1'b0;
    end else begin
      if (drop_fire) begin
        drop_flag_reg <= 1'b1; // [RQ16]
      end else if (wr_flags && !WDATA[FLG_DROP]) begin
        drop_flag_reg <= 1'b0; // [RQ16]
      end
      if (bad_fire) begin
        bad_flag_reg <= 1'b1; // [RQ17]
      end else if (wr_flags && !WDATA[FLG_BAD]) begin
        bad_flag_reg <= 1'b0; // [RQ17]
      end
    end
  end
  // event vector and next interrupt state
  always_comb begin
    evt_vec = EVT_NONE;
    evt_vec[EVT_WDT] = wdt_evt;
    evt_vec[EVT_PIN] = pin_evt;
    evt_vec[EVT_DROP] = drop_fire;
    evt_vec[EVT_BAD] = bad_fire;
    // read clears, a new event in the same cycle survives
    irq_stat_next = (rd_stat ? EVT_NONE : irq_stat_reg) | evt_vec;
    irq_mask_next = wr_mask ? WDATA[EVT_N-1:0] : irq_mask_reg;
  end
  // interrupt status, mask and level
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_reg <= EVT_NONE;
      irq_mask_reg <= EVT_NONE;
      irq_reg <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end
  // flag register view, upper bits read zero
  always_comb begin
    flags_rd = '0;
    flags_rd[FLG_TIMEOUT] = timeout_reg;
    flags_rd[FLG_PDF] = pdf_reg;
    flags_rd[FLG_DROP] = drop_flag_reg;
    flags_rd[FLG_BAD] = bad_flag_reg;
  end
  // read data stand one cycle, zero otherwise and when unmapped
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= '0;
    end else if (RD) begin
      unique case (ADDR)
        OFS_SEL: rdata_reg <= sel_reg;
        OFS_FLAGS: rdata_reg <= flags_rd;
        OFS_IRQ_STAT: rdata_reg <= {{(DATA_W-EVT_N){1'b0}}, irq_stat_reg};
        OFS_IRQ_MASK: rdata_reg <= {{(DATA_W-EVT_N){1'b0}}, irq_mask_reg};
        default: rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end
  // start-up length for the active clock source
  always_comb begin
    unique case (CLK_SOURCE)
      SRC_HXT: start_load = STARTUP_HXT_CYC - CNT_ONE; // [RQ1]
      SRC_SLOW_INTERNAL_RC: start_load = STARTUP_SLOW_INTERNAL_RC_CYC - CNT_ONE; // [RQ1]
      default: start_load = STARTUP_FAST_INTERNAL_RC_CYC - CNT_ONE; // [RQ1]
    endcase
  end

  // start-up counter; only a low-power watchdog wake loads it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      start_cnt_reg <= CNT_ZERO;
    end else if (full_evt) begin
      start_cnt_reg <= CNT_ZERO;
    end else if (wdt_evt) begin
      start_cnt_reg <= start_load; // [RQ1]
    end else if (start_cnt_reg != CNT_ZERO) begin
      start_cnt_reg <= start_cnt_reg - CNT_ONE;
    end
  end

  // run enable low through reset and start-up
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= !any_evt && pin_n_s && (start_cnt_reg == CNT_ZERO); // [RQ1]
    end
  end

  // reset and initialisation pulses to the core
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      core_reset_reg <= 1'b1;
      core_init_reg <= 1'b1; // [RQ6] [RQ8] [RQ9] [RQ10]
      pc_clear_reg <= 1'b1;
      wdt_clear_reg <= 1'b1; // [RQ7]
      wdt_run_reg <= 1'b0;
      por_pulse_reg <= 1'b1;
    end else begin
      core_reset_reg <= any_evt || !pin_n_s;
      // idle watchdog wake keeps the core state [RQ15]
      core_init_reg <= full_evt; // [RQ15]
      pc_clear_reg <= any_evt; // [RQ15]
      wdt_clear_reg <= any_evt;
      wdt_run_reg <= 1'b1; // counts right after the clear [RQ7]
      por_pulse_reg <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = rdata_reg;
  assign CORE_RESET = core_reset_reg;
  assign RUN_ENABLE = run_reg;
  assign CORE_INIT = core_init_reg;
  assign PC_STACK_CLEAR = pc_clear_reg;
  assign WDT_CLEAR = wdt_clear_reg;
  assign WDT_RUN = wdt_run_reg;
  assign THRESHOLD_CODE = sel_reg;
  assign TIMEOUT_FLAG = timeout_reg;
  assign POWER_DOWN_FLAG = pdf_reg;
  assign IRQ = irq_reg;

  // checks on the flags
  a_por_flags_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ2]
    por_pulse_reg |-> !timeout_reg && !pdf_reg && !drop_flag_reg)
    else $error("flags not clear after power-on");
  a_pin_keeps_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ3]
    (pin_evt || drop_fire) && !wdt_evt |=> $stable(timeout_reg) && $stable(pdf_reg))
    else $error("pin or drop reset changed flags");
  a_wdt_run_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ4]
    wdt_evt && !low_power |=> timeout_reg && $stable(pdf_reg))
    else $error("running watchdog reset flags wrong");
  // a same-cycle pin or delayed reset still asks for full init
  a_wdt_sleep_flags: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ5]
    wdt_evt && low_power && !full_evt |=> timeout_reg && pdf_reg && pc_clear_reg && !core_init_reg)
    else $error("low-power watchdog reset flags wrong");
  // checks on start-up and power-on state
  a_startup_hxt_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ1]
    wdt_evt && low_power && (CLK_SOURCE == SRC_HXT) |=> (!run_reg) [*8])
    else $error("crystal start-up delay too short");
  a_startup_slow_internal_rc_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ1]
    wdt_evt && low_power && (CLK_SOURCE == SRC_SLOW_INTERNAL_RC) && !full_evt
    |=> !run_reg && start_cnt_reg == CNT_ONE)
    else $error("slow rc start-up length wrong");
  // only the first edge after release, not the release edge itself
  a_por_core_state: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ7]
    por_pulse_reg && RST_N |-> core_init_reg && wdt_clear_reg && !wdt_run_reg ##1 wdt_run_reg)
    else $error("power-on state not applied");
  // checks on the threshold select
  a_sel_por_value: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ12]
    por_pulse_reg |-> sel_reg == SEL_POR)
    else $error("threshold select not at power-on code");
  a_bad_code_reload: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ13]
    bad_fire |=> sel_reg == SEL_POR && bad_flag_reg && core_reset_reg)
    else $error("bad code not reloaded");
  a_drop_keeps_sel: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ14]
    drop_fire && !bad_fire && !wr_sel |=> $stable(sel_reg) && drop_flag_reg)
    else $error("supply drop changed threshold select");
  a_bad_needs_code: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [RQ11]
    bad_fire |-> !code_ok)
    else $error("reset fired on a valid code");
  // main scenarios
  c_wdt_sleep: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
    wdt_evt && low_power ##1 !run_reg);
  c_bad_code: cover property (@(posedge SYS_CLK) disable iff (!RST_N) bad_fire);
  c_drop_reset: cover property (@(posedge SYS_CLK) disable iff (!RST_N) drop_fire);
  c_pin_irq: cover property (@(posedge SYS_CLK) disable iff (!RST_N) pin_evt ##1 irq_reg);
endmodule : reset_flags_and_supply_drop_select
`default_nettype wire

//--- reset_flags_and_supply_drop_select_test.sv
`timescale 1ns/1ns
`default_nettype none
module reset_flags_and_supply_drop_select_test;
  import rst_seq_pkg::*;
  // shortened slow tick so delayed resets stay quick
  localparam int unsigned T_DIV = 4;
  localparam int unsigned T_TICKS = 3;
  // clock, reset and register port
  logic sys_clk;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  // reset sources and core state
  logic pin_n;
  logic supply_low;
  logic wdt_to;
  logic [1:0] pmode;
  logic [1:0] csrc;
  // outputs to the core
  logic core_reset, run_enable, core_init, pc_clr, wdt_clr, wdt_run;
  logic [7:0] thr_code;
  logic to_flag, pd_flag, irq;
  // bookkeeping
  int err_count;
  int cmp_count;
  int n;

  reset_flags_and_supply_drop_select #(.DIV(T_DIV), .DELAY_TICKS(T_TICKS)) dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EXT_RESET_PIN_N(pin_n), .SUPPLY_LOW(supply_low), .WDT_TIMEOUT(wdt_to), .POWER_MODE(pmode),
    .CLK_SOURCE(csrc), .CORE_RESET(core_reset), .RUN_ENABLE(run_enable), .CORE_INIT(core_init),
    .PC_STACK_CLEAR(pc_clr), .WDT_CLEAR(wdt_clr), .WDT_RUN(wdt_run), .THRESHOLD_CODE(thr_code),
    .TIMEOUT_FLAG(to_flag), .POWER_DOWN_FLAG(pd_flag), .IRQ(irq)
  );

  // 40 ns system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // compare one value, count and report
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one-cycle register write
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // one-cycle read, data compared in the following cycle
  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // watchdog time-out pulse in a given mode and clock source
  task wdt_pulse(input logic [1:0] m, input logic [1:0] s);
    @(posedge sys_clk);
    wdt_to <= 1'b1;
    pmode <= m;
    csrc <= s;
    @(posedge sys_clk);
    wdt_to <= 1'b0;
    #1;
  endtask : wdt_pulse

  // bounded wait for the core reset pulse
  task wait_rst;
    n = 0;
    while (core_reset !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_rst

  // watchdog against a hung run
  initial begin
    #(40 * 6000);
    err_count++;
    report_and_stop;
  end

  // main sequence
  initial begin
    err_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    pin_n = 1'b1;
    supply_low = 1'b0;
    wdt_to = 1'b0;
    pmode = MODE_NORMAL;
    csrc = SRC_FAST_INTERNAL_RC;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    // power-on state of flags, code and watchdog
    check(to_flag, 1'b0);
    check(pd_flag, 1'b0);
    check(wdt_run, 1'b1);
    check(thr_code, 8'h55);
    rd_chk(OFS_SEL, 8'h55);
    rd_chk(OFS_FLAGS, 8'h00);
    rd_chk(OFS_IRQ_MASK, 8'h00);
    rd_chk(4'h7, 8'h00);
    // every valid code is kept and causes no reset
    for (int i = 0; i < 4; i++) begin
      logic [7:0] c;
      c = (i == 0) ? 8'h33 : (i == 1) ? 8'h99 : (i == 2) ? 8'haa : 8'h55;
      wr_reg(OFS_SEL, c);
      rd_chk(OFS_SEL, c);
    end
    wait_rst;
    check(core_reset, 1'b0);
    // watchdog in normal mode: time-out flag only, full init
    wr_reg(OFS_IRQ_MASK, 8'h0f);
    wdt_pulse(MODE_NORMAL, SRC_FAST_INTERNAL_RC);
    check({core_reset, core_init, pc_clr, wdt_clr, run_enable}, 8'h1e);
    check({to_flag, pd_flag}, 8'h02);
    @(posedge sys_clk);
    #1;
    check(irq, 1'b1);
    rd_chk(OFS_IRQ_STAT, 8'h01);
    @(posedge sys_clk);
    #1;
    check(irq, 1'b0);
    // pin reset holds the core and keeps both flags
    @(posedge sys_clk);
    pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    check({core_reset, run_enable}, 8'h02);
    check({to_flag, pd_flag}, 8'h02);
    @(posedge sys_clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    check({core_reset, run_enable}, 8'h01);
    rd_chk(OFS_IRQ_STAT, 8'h02);
    // low-power watchdog wakes, start-up delay per clock source
    for (int i = 0; i < 3; i++) begin
      logic [1:0] s;
      int exp_n;
      s = (i == 0) ? SRC_FAST_INTERNAL_RC : (i == 1) ? SRC_HXT : SRC_SLOW_INTERNAL_RC;
      exp_n = (i == 0) ? 16 : (i == 1) ? 128 : 2;
      wdt_pulse((i == 1) ? MODE_IDLE : MODE_SLEEP, s);
      check({pc_clr, core_init, to_flag, pd_flag}, 8'h0b);
      n = 0;
      while (run_enable !== 1'b1 && n < 300) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      check(n[7:0], exp_n[7:0]);
      rd_chk(OFS_IRQ_STAT, 8'h01);
    end
    // supply drop: delayed reset, code kept, drop flag set
    wr_reg(OFS_SEL, 8'h99);
    @(posedge sys_clk);
    pmode <= MODE_NORMAL;
    supply_low <= 1'b1;
    #1;
    wait_rst;
    check(8'(n >= 2 * T_DIV && n <= 3 * T_DIV + 4), 8'h01);
    @(posedge sys_clk);
    supply_low <= 1'b0;
    #1;
    check(thr_code, 8'h99);
    rd_chk(OFS_FLAGS, 8'h07);
    wr_reg(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 8'h03);
    rd_chk(OFS_IRQ_STAT, 8'h04);
    // undefined code: delayed reset and reload of the power-on code
    wr_reg(OFS_SEL, 8'h00);
    #1;
    wait_rst;
    check(8'(n >= 2 * T_DIV && n <= 3 * T_DIV + 4), 8'h01);
    check(core_init, 1'b1);
    rd_chk(OFS_SEL, 8'h55);
    check(thr_code, 8'h55);
    rd_chk(OFS_FLAGS, 8'h0b);
    wr_reg(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 8'h03);
    rd_chk(OFS_IRQ_STAT, 8'h08);
    // masked event stays sticky but raises no interrupt
    wr_reg(OFS_IRQ_MASK, 8'h00);
    wdt_pulse(MODE_SLOW, SRC_FAST_INTERNAL_RC);
    check({to_flag, pd_flag}, 8'h03);
    @(posedge sys_clk);
    #1;
    check(irq, 1'b0);
    rd_chk(OFS_IRQ_STAT, 8'h01);
    // supply drop ignored while powered down
    @(posedge sys_clk);
    pmode <= MODE_SLEEP;
    supply_low <= 1'b1;
    #1;
    wait_rst;
    check(core_reset, 1'b0);
    check(thr_code, 8'h55);
    rd_chk(OFS_FLAGS, 8'h03);
    @(posedge sys_clk);
    supply_low <= 1'b0;
    report_and_stop;
  end
endmodule : reset_flags_and_supply_drop_select_test
`default_nettype wire
